// *** design/smbr_consts.vh ***
/*
 * Constants for the static memory burst read sequencer: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
// Behaviour
// - A burst is two to four successive reads, count set by software.
// - At minimum wait programming a four-read burst waits 1-0-0-0.
// - Accesses stretch in whole clocks, by wait count, ready low, or both.
// - Ready is sampled on the expansion clock falling edge before transfer.
// - Ready low postpones transfer one period, then sampled again.
// - Sequential mode takes wait count from the sequential wait field.
// - Sequential mode inserts no idle cycle between successive reads.
// - Address, halfword, word and direction hold until next access starts.
// - Expansion clock and expansion ready are inputs to the device.
`ifndef SMBR_CONSTS_VH
`define SMBR_CONSTS_VH

// Register byte offsets
`define SMBR_OFS_CTRL 4'h0
`define SMBR_OFS_ADDR 4'h4
`define SMBR_OFS_CMD 4'h8
`define SMBR_OFS_STATUS 4'hC
`define SMBR_OFS_DATA0 4'h0

// Control fields
`define SMBR_CTRL_LEN_LSB 0
`define SMBR_CTRL_LEN_MSB 2
`define SMBR_CTRL_WS_LSB 4
`define SMBR_CTRL_WS_MSB 7
`define SMBR_CTRL_SWS_LSB 8
`define SMBR_CTRL_SWS_MSB 11
`define SMBR_CTRL_SQ_BIT 12
`define SMBR_CTRL_WORD_BIT 13
`define SMBR_CTRL_RESET 14'h0004

// Status fields
`define SMBR_ST_BUSY_BIT 0
`define SMBR_ST_DONE_BIT 1

// Burst limits and address steps
`define SMBR_LEN_MIN 3'h2
`define SMBR_LEN_MAX 3'h4
`define SMBR_STEP_WORD 28'h0000004
`define SMBR_STEP_HALF 28'h0000002

// Timing: first access of a burst carries one extra wait state
`define SMBR_FIRST_EXTRA_WS 5'h01
`define SMBR_IDLE_GAP_CYCLES 2'h1

`endif

// *** design/smbr_burst_read.v ***
/*
 * Static memory burst read sequencer with its Avalon-MM register slave.
 * Assumes the expansion clock and ready pins are asynchronous to clock,
 * and that read data from memory is stable while the access is stretched.
 */
`timescale 1ns/1ps
`include "smbr_consts.vh"

module smbr_burst_read (
  input wire clock,
  input wire resetn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire expansion_clock_in,
  input wire expansion_ready_in,
  input wire [31:0] mem_data_in,
  output reg [27:0] mem_address,
  output reg mem_chip_select_n,
  output reg mem_output_enable_n,
  output reg mem_halfword,
  output reg mem_word,
  output reg mem_write
);

  localparam ST_IDLE = 3'h0;
  localparam ST_GAP = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_EDGE = 3'h3;
  localparam ST_CAPT = 3'h4;

  // Clamp a programmed burst length into the legal range
  function [2:0] smbr_clamp_len;
    input [2:0] len;
    begin
      if (len < `SMBR_LEN_MIN)
        smbr_clamp_len = `SMBR_LEN_MIN;
      else if (len > `SMBR_LEN_MAX)
        smbr_clamp_len = `SMBR_LEN_MAX;
      else
        smbr_clamp_len = len;
    end
  endfunction

  reg [13:0] ctrl;
  reg [27:0] start_addr;
  reg busy;
  reg done;
  reg [2:0] state;
  reg [2:0] burst_len;
  reg [1:0] index;
  reg [4:0] wait_count;
  reg seq_mode;
  reg [31:0] data_buf [0:3];
  reg clk_s1, clk_s2, clk_s3;
  reg rdy_s1, rdy_s2;
  reg [31:0] dat_s1, dat_s2;

  wire bus_write = avs_write && !avs_waitrequest;
  wire start_req = bus_write && (avs_address[5:2] == (`SMBR_OFS_CMD >> 2)) &&
    avs_writedata[0] && !busy;
  wire clr_done = bus_write && (avs_address[5:2] == (`SMBR_OFS_STATUS >> 2)) &&
    avs_writedata[`SMBR_ST_DONE_BIT];
  wire exp_fall = clk_s3 && !clk_s2;
  wire last_access = ({1'b0, index} == burst_len - 3'h1);
  wire [27:0] step = ctrl[`SMBR_CTRL_WORD_BIT] ? `SMBR_STEP_WORD : `SMBR_STEP_HALF;

  // Pin synchronisers; ready may change at any time relative to clock
  always @(posedge clock) begin
    if (!resetn) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      dat_s1 <= 32'h00000000;
      dat_s2 <= 32'h00000000;
    end else begin
      clk_s1 <= expansion_clock_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2; // Edge detect looks only at second stage onward
      rdy_s1 <= expansion_ready_in;
      rdy_s2 <= rdy_s1;
      dat_s1 <= mem_data_in;
      dat_s2 <= dat_s1;
    end
  end

  // Avalon slave: one cycle of waitrequest low answers each request
  always @(posedge clock) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        if (avs_address[5])
          avs_readdata <= data_buf[avs_address[3:2]];
        else begin
          case (avs_address[5:2])
            (`SMBR_OFS_CTRL >> 2): avs_readdata <= {18'h00000, ctrl};
            (`SMBR_OFS_ADDR >> 2): avs_readdata <= {4'h0, start_addr};
            (`SMBR_OFS_STATUS >> 2): avs_readdata <= {29'h00000000, index == 2'h0 ?
              1'b0 : 1'b1, done, busy};
            default: avs_readdata <= 32'h00000000;
          endcase
        end
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Configuration registers, written at the acknowledging edge
  always @(posedge clock) begin
    if (!resetn) begin
      ctrl <= `SMBR_CTRL_RESET;
      start_addr <= 28'h0000000;
    end else if (bus_write && !avs_address[5]) begin
      if (avs_address[5:2] == (`SMBR_OFS_CTRL >> 2))
        ctrl <= avs_writedata[13:0];
      if (avs_address[5:2] == (`SMBR_OFS_ADDR >> 2))
        start_addr <= avs_writedata[27:0];
    end
  end

  // Done flag: a burst ending in the clearing cycle still sets it
  always @(posedge clock) begin
    if (!resetn)
      done <= 1'b0;
    else if (state == ST_CAPT && last_access)
      done <= 1'b1;
    else if (clr_done)
      done <= 1'b0;
  end

  // Read sequencer
  always @(posedge clock) begin
    if (!resetn) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      burst_len <= `SMBR_LEN_MIN;
      index <= 2'h0;
      wait_count <= 5'h00;
      seq_mode <= 1'b0;
      mem_address <= 28'h0000000;
      mem_chip_select_n <= 1'b1;
      mem_output_enable_n <= 1'b1;
      mem_halfword <= 1'b0;
      mem_word <= 1'b0;
      mem_write <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            busy <= 1'b1;
            burst_len <= smbr_clamp_len(ctrl[`SMBR_CTRL_LEN_MSB:`SMBR_CTRL_LEN_LSB]);
            seq_mode <= ctrl[`SMBR_CTRL_SQ_BIT];
            index <= 2'h0;
            mem_address <= start_addr;
            mem_word <= ctrl[`SMBR_CTRL_WORD_BIT];
            mem_halfword <= !ctrl[`SMBR_CTRL_WORD_BIT];
            mem_write <= 1'b0;
            mem_chip_select_n <= 1'b0;
            mem_output_enable_n <= 1'b0;
            // First access always carries the extra wait state
            wait_count <= {1'b0, ctrl[`SMBR_CTRL_WS_MSB:`SMBR_CTRL_WS_LSB]} +
              `SMBR_FIRST_EXTRA_WS;
            state <= ST_WAIT;
          end
        end
        ST_GAP: begin
          // Idle cycle between non-sequential reads; address held
          mem_chip_select_n <= 1'b0;
          mem_output_enable_n <= 1'b0;
          mem_address <= mem_address + step;
          wait_count <= {1'b0, ctrl[`SMBR_CTRL_WS_MSB:`SMBR_CTRL_WS_LSB]};
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          // Programmed wait states, one whole clock each
          if (wait_count != 5'h00)
            wait_count <= wait_count - 5'h01;
          else
            state <= ST_EDGE;
        end
        ST_EDGE: begin
          // Ready sampled at each expansion clock fall; low means retry
          if (exp_fall && rdy_s2)
            state <= ST_CAPT;
        end
        ST_CAPT: begin
          if (last_access) begin
            busy <= 1'b0;
            mem_chip_select_n <= 1'b1;
            mem_output_enable_n <= 1'b1;
            state <= ST_IDLE; // Pins keep last address, halfword and word
          end else begin
            index <= index + 2'h1;
            if (seq_mode) begin
              // Back to back, sequential wait count
              mem_address <= mem_address + step;
              wait_count <= {1'b0, ctrl[`SMBR_CTRL_SWS_MSB:`SMBR_CTRL_SWS_LSB]};
              state <= ST_WAIT;
            end else begin
              mem_chip_select_n <= 1'b1;
              mem_output_enable_n <= 1'b1;
              state <= ST_GAP;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Read data capture slots, one per access of the burst
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_slot
      always @(posedge clock) begin
        if (!resetn)
          data_buf[gi] <= 32'h00000000;
        else if (state == ST_CAPT && index == gi)
          data_buf[gi] <= dat_s2;
      end
    end
  endgenerate

endmodule // smbr_burst_read

// *** dv/smbr_mem_model.sv ***
/* Far-side memory model for the burst reader.
   Assumes active-low enables from the sequencer. */
`timescale 1ns/1ps
module smbr_mem_model (
  input wire [27:0] mem_address,
  input wire mem_output_enable_n,
  input wire stall,
  output reg expansion_clock_in,
  output wire expansion_ready_in,
  output wire [31:0] mem_data_in
);
  reg [31:0] last = 32'h0;
  // Free running, phase unrelated to clock
  initial begin
    expansion_clock_in = 1'b0;
    #37; // Offset so its edges never land on a system clock edge
    forever #150 expansion_clock_in = ~expansion_clock_in;
  end
  // Ready ignores the expansion clock phase
  assign expansion_ready_in = ~stall;
  // Released bus shows the inverse, so stale reads show up
  always @(mem_address or mem_output_enable_n) if (!mem_output_enable_n) last = {4'hA, mem_address};
  assign mem_data_in = mem_output_enable_n ? ~last : last;
endmodule // smbr_mem_model

// *** dv/smbr_burst_read_props.sv ***
/* Port checker for the burst reader.
   Assumes one clock domain; attached by bind. */
`timescale 1ns/1ps
module smbr_props (
  input wire clock,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire expansion_ready_in,
  input wire [27:0] mem_address,
  input wire mem_chip_select_n,
  input wire mem_output_enable_n,
  input wire mem_word,
  input wire mem_write
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Bus handshake timing
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait");
  wait_rest_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("rest");
  read_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("rdata");
  // Memory side
  read_only_a: assert property (!mem_write) else $error("write");
  oe_cs_a: assert property (mem_output_enable_n == mem_chip_select_n) else $error("oe");
  addr_hold_a: assert property (mem_chip_select_n[*4] |-> $stable(mem_address) && $stable(mem_word))
    else $error("addr hold");
  stall_hold_a: assert property (!expansion_ready_in[*8] |-> $stable(mem_address))
    else $error("stall");
  burst_c: cover property ($fell(mem_chip_select_n));
  stall_c: cover property (!expansion_ready_in[*8]);
  read_c: cover property (avs_read && !avs_waitrequest);
endmodule // smbr_props
bind smbr_burst_read smbr_props u_smbr_props (.clock, .resetn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .expansion_ready_in, .mem_address, .mem_chip_select_n,
  .mem_output_enable_n, .mem_word, .mem_write);

// *** dv/smbr_burst_read_tb.sv ***
/* Testbench for the burst reader: bus tasks and burst scenarios.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ps
module smbr_burst_read_tb;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg stall = 1'b0;
  reg prev_cs = 1'b1;
  reg [31:0] rdv;
  wire [31:0] avs_readdata, mem_data_in;
  wire avs_waitrequest, expansion_clock_in, expansion_ready_in;
  wire [27:0] mem_address;
  wire mem_chip_select_n, mem_output_enable_n, mem_halfword, mem_word, mem_write;
  integer fails = 0;
  integer compares = 0;
  integer starts = 0;
  integer cs_low = 0;
  smbr_burst_read u_smbr_burst_read (.clock, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .expansion_clock_in, .expansion_ready_in,
    .mem_data_in, .mem_address, .mem_chip_select_n, .mem_output_enable_n, .mem_halfword,
    .mem_word, .mem_write);
  smbr_mem_model u_smbr_mem_model (.mem_address, .mem_output_enable_n, .stall,
    .expansion_clock_in, .expansion_ready_in, .mem_data_in);
  initial begin
    forever #50 clock = ~clock;
  end
  // Access starts seen as chip select falls
  always @(posedge clock) begin
    if (prev_cs && !mem_chip_select_n) starts <= starts + 1;
    prev_cs <= mem_chip_select_n;
  end
  // Cycles with chip select low, the summed length of a burst's accesses
  always @(posedge clock) begin
    if (mem_chip_select_n === 1'b0) cs_low <= cs_low + 1;
  end
  // One request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("Error waitrequest expected 0 seen 1");
    end
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Cycle counts jitter with the expansion clock phase, so a window is judged
  task automatic chk_range(input string what, input integer lo, input integer hi,
                           input integer got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Reset value and an unmapped place
  task automatic t_regs;
    bus(0, 6'h00, 32'h0);
    chk("ctrl", 32'h00000004, rdv);
    bus(1, 6'h10, 32'hFFFFFFFF);
    bus(0, 6'h10, 32'h0);
    chk("unmapped", 32'h0, rdv);
  endtask
  // Reset in mid-burst returns pins and registers to rest
  task automatic t_reset;
    stall <= 1'b1;
    bus(1, 6'h08, 32'h1);
    repeat (5) @(posedge clock);
    resetn <= 1'b0;
    stall <= 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("select", 32'h1, {31'h0, mem_chip_select_n});
    chk("enable", 32'h1, {31'h0, mem_output_enable_n});
    bus(0, 6'h0C, 32'h0);
    chk("status", 32'h0, rdv);
    bus(0, 6'h00, 32'h0);
    chk("ctrl", 32'h00000004, rdv);
  endtask
  // Programs one burst, optionally stalls ready, then checks the words
  task automatic t_burst(input logic [2:0] len, input logic [3:0] ws, input logic [3:0] sws,
                         input logic sq, input logic word, input integer hold);
    logic [27:0] base, st;
    logic [2:0] n;
    integer i, s0, c0, lo, w2;
    base = 28'h0001000;
    st = word ? 28'h0000004 : 28'h0000002;
    n = (len > 3'h4) ? 3'h4 : len;
    // Each access: its wait count plus three to five cycles of edge wait and capture
    w2 = sq ? sws : ws;
    lo = ws + 1 + (n - 1) * w2 + 3 * n;
    bus(1, 6'h00, {18'h0, word, sq, sws, ws, 1'b0, len});
    bus(1, 6'h04, {4'h0, base});
    s0 = starts;
    c0 = cs_low;
    stall <= (hold != 0);
    bus(1, 6'h08, 32'h1);
    repeat (hold) @(posedge clock);
    bus(0, 6'h0C, 32'h0);
    if (hold != 0) chk("busy", 32'h1, {31'h0, rdv[0]});
    if (hold != 0) chk("index", 32'h0, {31'h0, rdv[2]});
    stall <= 1'b0;
    i = 0;
    while (rdv[1] !== 1'b1 && i < 100) begin
      bus(0, 6'h0C, 32'h0);
      i++;
    end
    chk("done", 32'h1, {31'h0, rdv[1]});
    chk("index", 32'h1, {31'h0, rdv[2]});
    chk("word", {31'h0, word}, {31'h0, mem_word});
    chk("halfword", {31'h0, !word}, {31'h0, mem_halfword});
    chk("write", 32'h0, {31'h0, mem_write});
    chk("select", 32'h1, {31'h0, mem_chip_select_n});
    chk("enable", 32'h1, {31'h0, mem_output_enable_n});
    if (hold == 0) chk_range("access cycles", lo, lo + 2 * n, cs_low - c0);
    else chk_range("stalled cycles", lo + 2 * n + 1, lo + 2 * n + 200, cs_low - c0);
    chk("last addr", {4'h0, base + st * (n - 3'h1)}, {4'h0, mem_address});
    chk("starts", sq ? 32'h1 : {29'h0, n}, starts - s0);
    for (i = 0; i < n; i++) begin
      bus(0, 6'h20 + {i[3:0], 2'b00}, 32'h0);
      chk("data", {4'hA, base + st * i[27:0]}, rdv);
    end
    bus(1, 6'h0C, 32'h2);
  endtask
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short after about 50000 cycles
  initial begin
    #5000000;
    fails++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    t_burst(3'h2, 4'h0, 4'h0, 1'b1, 1'b1, 0);
    t_burst(3'h3, 4'hF, 4'h1, 1'b1, 1'b1, 0);
    t_burst(3'h4, 4'h0, 4'hF, 1'b0, 1'b1, 0);
    t_burst(3'h7, 4'h2, 4'h0, 1'b0, 1'b0, 0);
    t_burst(3'h3, 4'h1, 4'h1, 1'b1, 1'b1, 14);
    t_reset;
    summarize;
  end
endmodule // smbr_burst_read_tb
